/* File: src/pdma_consts.svh */
// offsets, field positions, reset values and sizes for the peripheral dma channel pair
`ifndef PDMA_CONSTS_SVH
`define PDMA_CONSTS_SVH

`define OFS_RX_ADDR        12'h100
`define OFS_RX_COUNT       12'h104
`define OFS_TX_ADDR        12'h108
`define OFS_TX_COUNT       12'h10C
`define OFS_RX_NEXT_ADDR   12'h110
`define OFS_RX_NEXT_COUNT  12'h114
`define OFS_TX_NEXT_ADDR   12'h118
`define OFS_TX_NEXT_COUNT  12'h11C
`define OFS_XFER_CTRL      12'h120
`define OFS_XFER_STAT      12'h124
`define OFS_IRQ_STATUS     12'h128
`define OFS_IRQ_MASK       12'h12C
`define OFS_XFER_SIZE      12'h130

`define CTRL_RX_EN_BIT     0
`define CTRL_RX_DIS_BIT    1
`define CTRL_TX_EN_BIT     8
`define CTRL_TX_DIS_BIT    9
`define STAT_RX_EN_BIT     0
`define STAT_TX_EN_BIT     8

`define EV_RX_END          0
`define EV_RX_FULL         1
`define EV_TX_END          2
`define EV_TX_EMPTY        3

`define COUNT_W            16
`define ADDR_RESET         32'h0000_0000
`define COUNT_RESET        16'h0000

`endif

/* File: src/pdma_pkg.sv */
// types shared by the peripheral dma channel pair
package pdma_pkg;
	// transfer width, selects pointer step of 1, 2 or 4
	typedef enum logic [1:0] {
		XFER_BYTE = 2'h0,
		XFER_HALF = 2'h1,
		XFER_WORD = 2'h2
	} xfer_size_e;

	// bus engine states, one-hot
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_RX   = 3'b010,
		ST_TX   = 3'b100
	} eng_state_e;
endpackage : pdma_pkg

/* File: src/pdma_channel.sv */
// one dma direction: current and next pointer/counter with chaining reload
`timescale 1ns/100ps
`default_nettype none
`include "pdma_consts.svh"

module pdma_channel
	import pdma_pkg::*;
(
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 wr_addr,
	input  wire logic                 wr_count,
	input  wire logic                 wr_next_addr,
	input  wire logic                 wr_next_count,
	input  wire logic [31:0]          wdata,
	input  wire logic                 xfer_done,
	input  wire logic [2:0]           step,
	output logic      [31:0]          cur_addr_q,
	output logic      [15:0]          cur_count_q,
	output logic      [31:0]          next_addr_q,
	output logic      [15:0]          next_count_q,
	output logic                      end_flag,
	output logic                      full_flag
);
	logic reload;
	logic [15:0] dec_count;

	assign dec_count = cur_count_q - 16'h0001;
	// chain when the running buffer finishes and a next buffer is waiting
	assign reload    = (cur_count_q == `COUNT_RESET) && (next_count_q != `COUNT_RESET);

	// current pointer and counter; a software write overrides the engine
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cur_addr_q  <= `ADDR_RESET;
			cur_count_q <= `COUNT_RESET;
		end
		else
		begin
			if (wr_addr)
				cur_addr_q <= wdata;
			// RULE11: reload from next
			else if (reload)
				cur_addr_q <= next_addr_q;
			// RULE12: pointer advance
			else if (xfer_done)
				cur_addr_q <= cur_addr_q + {29'h0, step};
			if (wr_count)
				cur_count_q <= wdata[15:0];
			else if (reload)
				cur_count_q <= next_count_q;
			// RULE12: counter decrement
			else if (xfer_done)
				cur_count_q <= dec_count;
		end
	end

	// next pointer and counter, upper count bits are not stored
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			next_addr_q  <= `ADDR_RESET;
			next_count_q <= `COUNT_RESET;
		end
		else
		begin
			// RULE1: next address store
			if (wr_next_addr)
				next_addr_q <= wdata;
			// RULE2: next count field
			if (wr_next_count)
				next_count_q <= wdata[15:0];
			// RULE11: next count cleared
			else if (reload)
				next_count_q <= `COUNT_RESET;
		end
	end

	// RULE13: end and full levels
	assign end_flag  = (cur_count_q == `COUNT_RESET);
	assign full_flag = end_flag && (next_count_q == `COUNT_RESET);
endmodule : pdma_channel
`default_nettype wire

/* File: src/pdma_top.sv */
// peripheral dma channel pair with apb registers, bus engine and interrupt
// Overview of operation
// RULE1: a 32-bit receive next address becomes the receive destination once the buffer fills.
// RULE2: the receive next count holds the chained buffer size in bits 15 to 0.
// RULE3: a 32-bit transmit next address becomes the transmit source once the buffer empties.
// RULE4: the transmit next count holds the chained buffer size in bits 15 to 0.
// RULE5: writing one to control bit 0 enables receive requests unless bit 1 is also one.
// RULE6: writing one to control bit 1 disables receive requests.
// RULE7: writing one to control bit 8 enables transmit requests.
// RULE8: writing one to control bit 9 disables transmit requests.
// RULE9: status bit 0 shows whether receive requests are enabled.
// RULE10: status bit 8 shows whether transmit requests are enabled.
// RULE11: at a zero counter the next values load into the current ones and next count clears.
// RULE12: each transfer decrements the counter and steps the pointer by 1, 2 or 4.
// RULE13: end flag at zero current count, full/empty flag when next count is zero too.
// RULE14: writing a current or next counter clears that channel's end flag.
// RULE15: if transmit enable and disable are written together, disable wins.
// RULE16: unused count and status bits read zero and ignore writes.
`timescale 1ns/100ps
`default_nettype none
`include "pdma_consts.svh"

module pdma_top
	import pdma_pkg::*;
(
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [11:0]          paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire logic                 rx_ready,
	input  wire logic                 tx_ready,
	input  wire logic [31:0]          periph_rx_data,
	output logic                      periph_rx_ack,
	output logic      [31:0]          periph_tx_data,
	output logic                      periph_tx_ack,
	output logic                      mem_req,
	output logic                      mem_write,
	output logic      [31:0]          mem_addr,
	output logic      [31:0]          mem_wdata,
	input  wire logic                 mem_ack,
	input  wire logic [31:0]          mem_rdata,
	output logic                      irq
);
	import pdma_pkg::*;

	logic        wr_en;
	logic        rd_en;
	logic        rx_en_q;
	logic        tx_en_q;
	logic [1:0]  size_q;
	logic [3:0]  irq_stat_q;
	logic [3:0]  irq_mask_q;
	logic [3:0]  ev_set;
	logic [3:0]  lvl_q;
	logic [3:0]  lvl_d;
	logic [2:0]  step;
	eng_state_e  state_q;
	logic        rx_done;
	logic        tx_done;
	logic        rx_rdy_s1_q, rx_rdy_q;
	logic        tx_rdy_s1_q, tx_rdy_q;
	logic [1:0]  xfer_hold_q;
	logic [3:0]  stat_clr;
	logic [31:0] rx_cur_addr, rx_next_addr, tx_cur_addr, tx_next_addr;
	logic [15:0] rx_cur_count, rx_next_count, tx_cur_count, tx_next_count;
	logic        rx_end_flag, rx_full_flag, tx_end_flag, tx_empty_flag;
	logic        rx_cnt_wr, tx_cnt_wr;

	// single-cycle apb slave, no wait states
	assign wr_en   = psel && penable && pwrite;
	assign rd_en   = psel && !penable && !pwrite;
	assign pready  = 1'b1;
	assign pslverr = 1'b0;

	// pointer step from transfer width
	assign step = (size_q == XFER_WORD) ? 3'h4 : (size_q == XFER_HALF) ? 3'h2 : 3'h1;

	// ready lines come from the peripheral clocking; resync before use
	// the synced copy lags two cycles, so it is ignored for two cycles after an ack
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_rdy_s1_q <= 1'b0;
			rx_rdy_q    <= 1'b0;
			tx_rdy_s1_q <= 1'b0;
			tx_rdy_q    <= 1'b0;
			xfer_hold_q <= 2'b00;
		end
		else
		begin
			rx_rdy_s1_q <= rx_ready;
			rx_rdy_q    <= rx_rdy_s1_q;
			tx_rdy_s1_q <= tx_ready;
			tx_rdy_q    <= tx_rdy_s1_q;
			xfer_hold_q <= (rx_done || tx_done) ? 2'b11 : {1'b0, xfer_hold_q[1]};
		end
	end

	// control register is write-only; enables live here
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_en_q <= 1'b0;
			tx_en_q <= 1'b0;
		end
		else if (wr_en && paddr == `OFS_XFER_CTRL)
		begin
			// RULE6: receive disable
			if (pwdata[`CTRL_RX_DIS_BIT])
				rx_en_q <= 1'b0;
			// RULE5: receive enable
			else if (pwdata[`CTRL_RX_EN_BIT])
				rx_en_q <= 1'b1;
			// RULE8: transmit disable
			// RULE15: disable wins
			if (pwdata[`CTRL_TX_DIS_BIT])
				tx_en_q <= 1'b0;
			// RULE7: transmit enable
			else if (pwdata[`CTRL_TX_EN_BIT])
				tx_en_q <= 1'b1;
		end
	end

	// transfer width register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			size_q <= XFER_BYTE;
		else if (wr_en && paddr == `OFS_XFER_SIZE)
			size_q <= pwdata[1:0];
	end

	// bus engine: receive served first, one transfer per memory handshake
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q        <= ST_IDLE;
			mem_req        <= 1'b0;
			mem_write      <= 1'b0;
			mem_addr       <= 32'h0000_0000;
			mem_wdata      <= 32'h0000_0000;
			periph_tx_data <= 32'h0000_0000;
		end
		else
		begin
			case (state_q)
				ST_IDLE:
				begin
					if (rx_en_q && rx_rdy_q && !rx_end_flag && !rx_cnt_wr && !xfer_hold_q[0])
					begin
						state_q   <= ST_RX;
						mem_req   <= 1'b1;
						mem_write <= 1'b1;
						mem_addr  <= rx_cur_addr;
						mem_wdata <= periph_rx_data;
					end
					else if (tx_en_q && tx_rdy_q && !tx_end_flag && !tx_cnt_wr && !xfer_hold_q[0])
					begin
						state_q   <= ST_TX;
						mem_req   <= 1'b1;
						mem_write <= 1'b0;
						mem_addr  <= tx_cur_addr;
					end
				end
				ST_RX:
				begin
					if (mem_ack)
					begin
						state_q <= ST_IDLE;
						mem_req <= 1'b0;
					end
				end
				ST_TX:
				begin
					if (mem_ack)
					begin
						state_q        <= ST_IDLE;
						mem_req        <= 1'b0;
						periph_tx_data <= mem_rdata;
					end
				end
				default:
				begin
					state_q <= ST_IDLE;
					mem_req <= 1'b0;
				end
			endcase
		end
	end

	assign rx_done       = (state_q == ST_RX) && mem_ack;
	assign tx_done       = (state_q == ST_TX) && mem_ack;
	assign periph_rx_ack = rx_done;
	assign periph_tx_ack = tx_done;
	assign rx_cnt_wr = wr_en && (paddr == `OFS_RX_COUNT || paddr == `OFS_RX_NEXT_COUNT);
	assign tx_cnt_wr = wr_en && (paddr == `OFS_TX_COUNT || paddr == `OFS_TX_NEXT_COUNT);

	// receive channel
	// RULE1: receive next pointer
	pdma_channel u_rx (
		.pclk          (pclk),
		.presetn       (presetn),
		.wr_addr       (wr_en && paddr == `OFS_RX_ADDR),
		.wr_count      (wr_en && paddr == `OFS_RX_COUNT),
		.wr_next_addr  (wr_en && paddr == `OFS_RX_NEXT_ADDR),
		.wr_next_count (wr_en && paddr == `OFS_RX_NEXT_COUNT),
		.wdata         (pwdata),
		.xfer_done     (rx_done),
		.step          (step),
		.cur_addr_q    (rx_cur_addr),
		.cur_count_q   (rx_cur_count),
		.next_addr_q   (rx_next_addr),
		.next_count_q  (rx_next_count),
		.end_flag      (rx_end_flag),
		.full_flag     (rx_full_flag)
	);

	// transmit channel
	// RULE3: transmit next pointer
	// RULE4: transmit next count
	pdma_channel u_tx (
		.pclk          (pclk),
		.presetn       (presetn),
		.wr_addr       (wr_en && paddr == `OFS_TX_ADDR),
		.wr_count      (wr_en && paddr == `OFS_TX_COUNT),
		.wr_next_addr  (wr_en && paddr == `OFS_TX_NEXT_ADDR),
		.wr_next_count (wr_en && paddr == `OFS_TX_NEXT_COUNT),
		.wdata         (pwdata),
		.xfer_done     (tx_done),
		.step          (step),
		.cur_addr_q    (tx_cur_addr),
		.cur_count_q   (tx_cur_count),
		.next_addr_q   (tx_next_addr),
		.next_count_q  (tx_next_count),
		.end_flag      (tx_end_flag),
		.full_flag     (tx_empty_flag)
	);

	// sticky events on rising edge of each flag level
	assign lvl_d  = {tx_empty_flag, tx_end_flag, rx_full_flag, rx_end_flag};
	assign ev_set = lvl_d & ~lvl_q;

	// flag levels start high so that reset does not fire events
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			lvl_q <= 4'hF;
		else
			lvl_q <= lvl_d;
	end

	// write-one clear from software; counter writes also drop the end bits (0 and 2)
	// RULE14: counter write clears end
	assign stat_clr = ((wr_en && paddr == `OFS_IRQ_STATUS) ? pwdata[3:0] : 4'h0)
		| {1'b0, tx_cnt_wr, 1'b0, rx_cnt_wr};

	// set beats clear in the same cycle, so no event is lost
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_stat_q <= 4'h0;
		else
			irq_stat_q <= (irq_stat_q & ~stat_clr) | ev_set;
	end

	// interrupt mask
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_mask_q <= 4'h0;
		else if (wr_en && paddr == `OFS_IRQ_MASK)
			irq_mask_q <= pwdata[3:0];
	end

	assign irq = |(irq_stat_q & irq_mask_q);

	// read data registered in setup so it is valid in the access phase
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (rd_en)
		begin
			if (paddr == `OFS_RX_ADDR)
				prdata <= rx_cur_addr;
			// RULE16: upper count bits zero
			else if (paddr == `OFS_RX_COUNT)
				prdata <= {16'h0000, rx_cur_count};
			else if (paddr == `OFS_TX_ADDR)
				prdata <= tx_cur_addr;
			else if (paddr == `OFS_TX_COUNT)
				prdata <= {16'h0000, tx_cur_count};
			else if (paddr == `OFS_RX_NEXT_ADDR)
				prdata <= rx_next_addr;
			else if (paddr == `OFS_RX_NEXT_COUNT)
				prdata <= {16'h0000, rx_next_count};
			else if (paddr == `OFS_TX_NEXT_ADDR)
				prdata <= tx_next_addr;
			else if (paddr == `OFS_TX_NEXT_COUNT)
				prdata <= {16'h0000, tx_next_count};
			// RULE9: receive enable status
			// RULE10: transmit enable status
			else if (paddr == `OFS_XFER_STAT)
				prdata <= {23'h0, tx_en_q, 7'h0, rx_en_q};
			else if (paddr == `OFS_IRQ_STATUS)
				prdata <= {28'h0, irq_stat_q};
			else if (paddr == `OFS_IRQ_MASK)
				prdata <= {28'h0, irq_mask_q};
			else if (paddr == `OFS_XFER_SIZE)
				prdata <= {30'h0, size_q};
			else
				prdata <= 32'h0000_0000;
		end
	end

	// control write with both bits set leaves receive disabled
	rx_dis_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en && paddr == `OFS_XFER_CTRL && pwdata[1] |=> !rx_en_q) // RULE6
		else $error("rx disable did not win");
	tx_dis_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en && paddr == `OFS_XFER_CTRL && pwdata[9] |=> !tx_en_q) // RULE15
		else $error("tx disable did not win");
	rx_enable_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en && paddr == `OFS_XFER_CTRL && pwdata[1:0] == 2'h1 |=> rx_en_q) // RULE5
		else $error("rx enable lost");
	tx_enable_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en && paddr == `OFS_XFER_CTRL && pwdata[9:8] == 2'h1 |=> tx_en_q) // RULE7
		else $error("tx enable lost");
	ctrl_zero_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en && paddr == `OFS_XFER_CTRL && pwdata[9:8] == 2'h0
		|=> tx_en_q == $past(tx_en_q)) // RULE8
		else $error("tx enable changed on zero write");
	status_read_a: assert property (@(posedge pclk) disable iff (!presetn)
		rd_en && paddr == `OFS_XFER_STAT |=> prdata[0] == $past(rx_en_q)
		&& prdata[8] == $past(tx_en_q) && prdata[7:1] == 7'h0) // RULE9
		else $error("status read mismatch");
	rx_reload_a: assert property (@(posedge pclk) disable iff (!presetn)
		rx_cur_count == 16'h0 && rx_next_count != 16'h0 && !wr_en
		|=> rx_cur_count == $past(rx_next_count) && rx_next_count == 16'h0
		&& rx_cur_addr == $past(rx_next_addr)) // RULE11
		else $error("rx chain reload wrong");
	rx_step_a: assert property (@(posedge pclk) disable iff (!presetn)
		rx_done && rx_cur_count != 16'h0 && !wr_en
		|=> rx_cur_count == $past(rx_cur_count) - 16'h1
		&& rx_cur_addr == $past(rx_cur_addr) + {29'h0, $past(step)}) // RULE12
		else $error("rx step wrong");
	tx_empty_ev_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(tx_empty_flag) |=> irq_stat_q[`EV_TX_EMPTY]) // RULE13
		else $error("tx empty event not latched");
	end_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		rx_cnt_wr && !ev_set[0] |=> !irq_stat_q[0]) // RULE14
		else $error("rx end not cleared");
	count_upper_a: assert property (@(posedge pclk) disable iff (!presetn)
		rd_en && paddr == `OFS_TX_NEXT_COUNT |=> prdata[31:16] == 16'h0) // RULE16
		else $error("upper count bits not zero");

	rx_xfer_c: cover property (@(posedge pclk) disable iff (!presetn) rx_done);
	tx_xfer_c: cover property (@(posedge pclk) disable iff (!presetn) tx_done);
	rx_chain_c: cover property (@(posedge pclk) disable iff (!presetn)
		rx_cur_count == 16'h0 && rx_next_count != 16'h0);
	irq_c: cover property (@(posedge pclk) disable iff (!presetn) irq);
endmodule : pdma_top
`default_nettype wire

/* File: test/pdma_partner.sv */
// far-side model: serial peripheral ready/data lines and a system memory
`timescale 1ns/100ps
`default_nettype none

module pdma_partner
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        slow,
	input  wire logic        load,
	input  wire logic [3:0]  rx_num,
	input  wire logic [3:0]  tx_num,
	input  wire logic        mem_req,
	input  wire logic [31:0] mem_addr,
	input  wire logic        rx_ack,
	input  wire logic        tx_ack,
	output logic             rx_ready,
	output logic             tx_ready,
	output logic      [31:0] rx_data,
	output var logic         mem_ack,
	output logic      [31:0] mem_rdata
);
	logic [3:0]  rx_left_q;
	logic [3:0]  tx_left_q;
	logic [3:0]  gap_q;
	logic [3:0]  wait_q;
	logic [7:0]  seq_q;
	logic [31:0] free_q;

	// word budget per direction; ready rests after each ack so the sync chain clears
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			{rx_left_q, tx_left_q, gap_q, seq_q} <= '0;
		else if (load)
			{rx_left_q, tx_left_q, seq_q} <= {rx_num, tx_num, 8'h00};
		else if (rx_ack || tx_ack)
		begin
			rx_left_q <= rx_left_q - 4'(rx_ack);
			tx_left_q <= tx_left_q - 4'(tx_ack);
			seq_q <= seq_q + 8'(rx_ack);
			gap_q <= 4'h3;
		end
		else if (gap_q != 4'h0)
			gap_q <= gap_q - 4'h1;
	end

	assign rx_ready = (rx_left_q != 4'h0) && (gap_q == 4'h0);
	assign tx_ready = (tx_left_q != 4'h0) && (gap_q == 4'h0);
	// an idle data line shows the inverse, so a stale word never matches
	assign rx_data = rx_ready ? {24'hA50000, seq_q} : ~{24'hA50000, seq_q};

	// memory answers after one or four waits; its bus is junk outside the ack
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			{mem_ack, wait_q, free_q} <= '0;
		else
		begin
			free_q <= free_q + 32'h1;
			mem_ack <= mem_req && !mem_ack && (wait_q == (slow ? 4'h3 : 4'h0));
			wait_q <= (mem_req && !mem_ack) ? wait_q + 4'h1 : 4'h0;
		end
	end

	assign mem_rdata = mem_ack ? ~mem_addr : free_q;
endmodule : pdma_partner
`default_nettype wire

/* File: test/periph_dma_next_buffer_ctrl_tb_top.sv */
// self-checking bench for the dma channel pair
`timescale 1ns/100ps
`default_nettype none
`include "pdma_consts.svh"

module periph_dma_next_buffer_ctrl_tb_top;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rx_data, tx_data, mem_addr, mem_wdata, mem_rdata;
	logic rx_ready, tx_ready, rx_ack, tx_ack, mem_req, mem_write, mem_ack;
	logic slow, load, txa;
	logic [3:0] rx_num, tx_num;
	logic [31:0] aq[$], dq[$], tq[$];
	logic wq[$];
	int num_errors, comparisons, cyc;
	localparam logic [11:0] CW [10] = '{12'h001, 12'h000, 12'h003, 12'h001, 12'h002,
		12'h100, 12'h000, 12'h300, 12'h100, 12'h200};
	localparam logic [11:0] CS [10] = '{12'h001, 12'h001, 12'h000, 12'h001, 12'h000,
		12'h100, 12'h100, 12'h000, 12'h100, 12'h000};

	pdma_top pdma_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_ready(rx_ready), .tx_ready(tx_ready), .periph_rx_data(rx_data),
		.periph_rx_ack(rx_ack), .periph_tx_data(tx_data), .periph_tx_ack(tx_ack),
		.mem_req(mem_req), .mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata), .irq(irq));

	pdma_partner pdma_partner_inst (.pclk(pclk), .presetn(presetn), .slow(slow), .load(load),
		.rx_num(rx_num), .tx_num(tx_num), .mem_req(mem_req), .mem_addr(mem_addr),
		.rx_ack(rx_ack), .tx_ack(tx_ack), .rx_ready(rx_ready), .tx_ready(tx_ready),
		.rx_data(rx_data), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

	// 200 MHz clock
	always #2.5 pclk = ~pclk;

	// logs memory beats and words handed to the peripheral mid-cycle, where they
	// are settled; cuts a hang short
	always @(negedge pclk)
	begin
		if (txa === 1'b1)
			tq.push_back(tx_data);
		txa = tx_ack;
		if ((mem_req === 1'b1) && (mem_ack === 1'b1))
		begin
			aq.push_back(mem_addr);
			dq.push_back(mem_wdata);
			wq.push_back(mem_write);
		end
		cyc++;
		if (cyc == 20000)
		begin
			num_errors++;
			close_out();
		end
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// one apb transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		apb(1'b1, a, d, r);
	endtask : wr

	task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] r;
		apb(1'b0, a, 32'h0, r);
		chk(what, exp, r);
	endtask : rdc

	task automatic t_regs;
		logic [11:0] o;
		for (int i = 0; i < 2; i++)
		begin
			o = 12'(8 * i);
			rdc("next addr", `OFS_RX_NEXT_ADDR + o, 32'h0);
			rdc("next count", `OFS_RX_NEXT_COUNT + o, 32'h0);
			wr(`OFS_RX_NEXT_ADDR + o, 32'hFFFF_FFFF);
			rdc("next addr", `OFS_RX_NEXT_ADDR + o, 32'hFFFF_FFFF);
			wr(`OFS_RX_NEXT_COUNT + o, 32'hFFFF_FFFF);
			rdc("reloaded next count", `OFS_RX_NEXT_COUNT + o, 32'h0);
			rdc("reloaded count", `OFS_RX_COUNT + o, 32'h0000_FFFF);
			rdc("reloaded addr", `OFS_RX_ADDR + o, 32'hFFFF_FFFF);
			wr(`OFS_RX_NEXT_COUNT + o, 32'h1234_5678);
			rdc("held next count", `OFS_RX_NEXT_COUNT + o, 32'h0000_5678);
			wr(`OFS_RX_NEXT_COUNT + o, 32'h0);
			wr(`OFS_RX_COUNT + o, 32'h0);
		end
	endtask : t_regs

	// every enable/disable code, alone and together; enable from the disabled state, the other codes from the enabled state
	task automatic t_ctrl;
		rdc("status", `OFS_XFER_STAT, 32'h0);
		for (int i = 0; i < 10; i++)
		begin
			wr(`OFS_XFER_CTRL, {20'h0, CW[i]});
			rdc("status", `OFS_XFER_STAT, {20'h0, CS[i]});
		end
	endtask : t_ctrl

	// chained transfer: n words from 0x1000, then m from 0x2000
	task automatic xfer(input logic tx, input logic [1:0] sz, input int n, input int m,
		input logic s);
		logic [11:0] o;
		logic [31:0] a;
		int k;
		o = tx ? 12'h8 : 12'h0;
		aq.delete();
		dq.delete();
		tq.delete();
		wq.delete();
		slow <= s;
		wr(`OFS_XFER_SIZE, {30'h0, sz});
		wr(`OFS_RX_ADDR + o, 32'h0000_1000);
		wr(`OFS_RX_COUNT + o, 32'(n));
		wr(`OFS_RX_NEXT_ADDR + o, 32'h0000_2000);
		wr(`OFS_RX_NEXT_COUNT + o, 32'(m));
		wr(`OFS_IRQ_STATUS, 32'hF);
		load <= 1'b1;
		rx_num <= tx ? 4'h0 : 4'(n + m);
		tx_num <= tx ? 4'(n + m) : 4'h0;
		@(posedge pclk);
		load <= 1'b0;
		repeat (10) @(posedge pclk);
		chk("beats while disabled", 32'h0, 32'(aq.size()));
		wr(`OFS_XFER_CTRL, tx ? 32'h100 : 32'h1);
		k = 0;
		while (aq.size() < n + m && k < 400)
		begin
			@(posedge pclk);
			k++;
		end
		repeat (20) @(posedge pclk);
		chk("beat total", 32'(n + m), 32'(aq.size()));
		for (k = 0; k < n + m; k++)
		begin
			a = (k < n) ? 32'h1000 + 32'(k << sz) : 32'h2000 + 32'((k - n) << sz);
			chk("mem addr", a, aq[k]);
			chk("mem write", {31'h0, !tx}, {31'h0, wq[k]});
			if (tx)
				chk("tx word", ~a, tq[k]);
			else
				chk("rx word", 32'hA500_0000 + 32'(k), dq[k]);
		end
		rdc("count", `OFS_RX_COUNT + o, 32'h0);
		rdc("next count", `OFS_RX_NEXT_COUNT + o, 32'h0);
		rdc("status", `OFS_XFER_STAT, tx ? 32'h100 : 32'h1);
		rdc("irq status", `OFS_IRQ_STATUS, tx ? 32'hC : 32'h3);
	endtask : xfer

	// end flag cleared by a counter write; mask and write-one-to-clear
	task automatic t_irq;
		wr(`OFS_IRQ_MASK, 32'h1);
		chk("irq", 32'h1, {31'h0, irq});
		wr(`OFS_RX_NEXT_COUNT, 32'h0);
		rdc("irq status", `OFS_IRQ_STATUS, 32'h2);
		chk("irq", 32'h0, {31'h0, irq});
		wr(`OFS_IRQ_MASK, 32'h2);
		chk("irq", 32'h1, {31'h0, irq});
		wr(`OFS_IRQ_STATUS, 32'h2);
		chk("irq", 32'h0, {31'h0, irq});
		wr(`OFS_IRQ_MASK, 32'h0);
		wr(`OFS_XFER_CTRL, 32'h2);
		rdc("unmapped", 12'h200, 32'h0);
		chk("slave error", 32'h0, {31'h0, pslverr});
	endtask : t_irq

	task automatic close_out;
		$display("mismatches %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : close_out

	// reset, then the scenarios in turn
	initial
	begin
		{pclk, presetn, psel, penable, pwrite, slow, load, txa} = '0;
		{paddr, pwdata, rx_num, tx_num} = '0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_ctrl();
		xfer(1'b0, 2'h2, 2, 1, 1'b0);
		t_irq();
		xfer(1'b1, 2'h0, 1, 2, 1'b1);
		wr(`OFS_XFER_CTRL, 32'h200);
		xfer(1'b0, 2'h1, 2, 0, 1'b0);
		close_out();
	end
endmodule : periph_dma_next_buffer_ctrl_tb_top
`default_nettype wire
